// ==== shared/host_irq_event_pkg.sv ====
// constants and types for the host interrupt event bits 22..6
// Functional notes
// - lost cycle: two synchs without cycle start
// - lost cycle may be predicted early
// - seconds bit 6 change sets 64s flag
// - cycle count lsb toggle sets synch
// - phy status request sets phy flag
// - failed access flagged before next access
// - phy bus reset sets reinit flag
// - self-id stream done sets ident flag
// - bus reset clears ident flag same cycle
// - sticky ident set with primary, survives bus reset
// - bits 14..10 always read zero
// - lock reply without ack_complete sets error
// - host error on posted write sets error
// - receive summary is unlatched masked or
// - transmit summary is unlatched masked or
// - set on edge or set port, clear port clears
// - clear port read returns events and mask
package host_irq_event_pkg;
    localparam logic [7:0] set_port_offset = 8'h80;
    localparam logic [7:0] clear_port_offset = 8'h84;
    localparam int missed_cycle_bit = 22;
    localparam int sixty_four_sec_bit = 21;
    localparam int new_iso_cycle_bit = 20;
    localparam int phy_request_bit = 19;
    localparam int phy_clock_missing_bit = 18;
    localparam int bus_reinit_bit = 17;
    localparam int node_ident_done_bit = 16;
    localparam int node_ident_sticky_bit = 15;
    localparam int atomic_reply_error_bit = 9;
    localparam int buffered_write_error_bit = 8;
    localparam int iso_receive_bit = 7;
    localparam int iso_transmit_bit = 6;
    localparam int seconds_watch_bit = 6;
    localparam logic [31:0] latched_mask = 32'h007f_8300;
    localparam logic [31:0] event_reset = 32'h0000_0000;
    localparam int iso_context_count = 8;
    localparam int source_count = 11;
    typedef enum logic [1:0] {
        cycle_idle,
        cycle_wait_start,
        cycle_wait_gap
    } cycle_state_type;
endpackage

// ==== logic/rise_detect.sv ====
// rising-edge detectors for the latched event sources
`timescale 1ns/10ps
`default_nettype none
module rise_detect #(
    parameter int width = 11
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic [width-1:0] i_level,
    output logic [width-1:0] o_rise
);
    logic [width-1:0] last;
    logic [width-1:0] next_last;
    always_comb begin
        next_last = i_enable ? i_level : last;
    end
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            last <= '0;
        end else begin
            last <= next_last;
        end
    end
    assign o_rise = i_level & ~last & {width{i_enable}};
endmodule
`default_nettype wire

// ==== logic/host_interrupt_event_bits.sv ====
// interrupt event bits 22..6 with set and clear ports
`timescale 1ns/10ps
`default_nettype none
module host_interrupt_event_bits #(
    parameter int iso_contexts = host_irq_event_pkg::iso_context_count
) (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic [31:0] i_int_mask,
    input wire logic i_cycle_count_lsb,
    input wire logic [6:0] i_cycle_seconds,
    input wire logic i_cycle_start_seen,
    input wire logic i_subaction_gap,
    input wire logic i_arb_reset_gap,
    input wire logic i_phy_status_irq,
    input wire logic i_phy_clock_present,
    input wire logic i_reg_access,
    input wire logic i_phy_bus_reset,
    input wire logic i_self_id_done,
    input wire logic i_lock_reply_no_ack,
    input wire logic i_posted_write_host_error,
    input wire logic [iso_contexts-1:0] i_iso_rx_event,
    input wire logic [iso_contexts-1:0] i_iso_rx_mask,
    input wire logic [iso_contexts-1:0] i_iso_tx_event,
    input wire logic [iso_contexts-1:0] i_iso_tx_mask,
    output logic [31:0] o_events
);
    import host_irq_event_pkg::*;

    // ********************************
    // cycle timing sources
    // ********************************
    logic lsb_last;
    logic next_lsb_last;
    logic sec_last;
    logic next_sec_last;
    logic cycle_synch;
    logic sec_change;
    logic missed;
    cycle_state_type cstate;
    cycle_state_type next_cstate;

    assign cycle_synch = i_clk_en && (i_cycle_count_lsb != lsb_last);
    assign sec_change = i_clk_en &&
        (i_cycle_seconds[seconds_watch_bit] != sec_last);

    always_comb begin
        next_lsb_last = i_clk_en ? i_cycle_count_lsb : lsb_last;
        next_sec_last = i_clk_en ? i_cycle_seconds[seconds_watch_bit]
                                 : sec_last;
        next_cstate = cstate;
        missed = 1'b0;
        if (i_clk_en) begin
            case (cstate)
                cycle_idle: begin
                    if (cycle_synch) begin
                        next_cstate = cycle_wait_gap;
                    end
                end
                cycle_wait_gap, cycle_wait_start: begin
                    if (i_cycle_start_seen) begin
                        next_cstate = cycle_synch ? cycle_wait_gap
                                                  : cycle_idle;
                    end else if (cycle_synch) begin
                        missed = 1'b1;
                        next_cstate = cycle_wait_gap;
                    end else if (i_arb_reset_gap) begin
                        missed = 1'b1;
                        next_cstate = cycle_idle;
                    end else if (cstate == cycle_wait_start) begin
                        missed = 1'b1;
                        next_cstate = cycle_idle;
                    end else if (i_subaction_gap) begin
                        next_cstate = cycle_wait_start;
                    end
                end
                default: begin
                    next_cstate = cycle_idle;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            lsb_last <= 1'b0;
            sec_last <= 1'b0;
            cstate <= cycle_idle;
        end else begin
            lsb_last <= next_lsb_last;
            sec_last <= next_sec_last;
            cstate <= next_cstate;
        end
    end

    // ********************************
    // access failure capture
    // ********************************
    // level high in the access cycle itself
    logic access_fail;
    assign access_fail = i_reg_access && !i_phy_clock_present;

    // ********************************
    // edge detection of level sources
    // ********************************
    logic [source_count-1:0] levels;
    logic [source_count-1:0] rises;
    assign levels = {i_phy_status_irq, access_fail, i_phy_bus_reset,
                     i_self_id_done, i_lock_reply_no_ack,
                     i_posted_write_host_error, 5'h00};

    rise_detect #(
        .width(source_count)
    ) u_rise (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_enable(i_clk_en),
        .i_level(levels),
        .o_rise(rises)
    );

    // ********************************
    // event register
    // ********************************
    logic [31:0] events;
    logic [31:0] next_events;
    logic [31:0] hw_set;
    logic [31:0] sw_set;
    logic [31:0] sw_clr;
    logic [31:0] view;
    logic [31:0] next_rdata;
    logic next_rvalid;

    always_comb begin
        hw_set = '0;
        hw_set[missed_cycle_bit] = missed;
        hw_set[sixty_four_sec_bit] = sec_change;
        hw_set[new_iso_cycle_bit] = cycle_synch;
        hw_set[phy_request_bit] = rises[10];
        hw_set[phy_clock_missing_bit] = rises[9];
        hw_set[bus_reinit_bit] = rises[8];
        hw_set[node_ident_done_bit] = rises[7];
        hw_set[node_ident_sticky_bit] = rises[7];
        hw_set[atomic_reply_error_bit] = rises[6];
        hw_set[buffered_write_error_bit] = rises[5];
        sw_set = (i_clk_en && i_reg_wr && i_reg_addr == set_port_offset)
                 ? i_reg_wdata : 32'h0000_0000;
        sw_clr = (i_clk_en && i_reg_wr && i_reg_addr == clear_port_offset)
                 ? i_reg_wdata : 32'h0000_0000;
        next_events = ((events & ~sw_clr) | sw_set | hw_set) & latched_mask;
        if (hw_set[bus_reinit_bit]) begin
            next_events[node_ident_done_bit] = 1'b0;
        end
    end

    always_comb begin
        view = events;
        view[iso_receive_bit] = |(i_iso_rx_event & i_iso_rx_mask);
        view[iso_transmit_bit] = |(i_iso_tx_event & i_iso_tx_mask);
        next_rvalid = i_clk_en ? i_reg_rd : o_reg_rvalid;
        next_rdata = o_reg_rdata;
        if (i_clk_en && i_reg_rd) begin
            if (i_reg_addr == clear_port_offset) begin
                next_rdata = view & i_int_mask;
            end else if (i_reg_addr == set_port_offset) begin
                next_rdata = view;
            end else begin
                next_rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            events <= event_reset;
            o_reg_rdata <= 32'h0000_0000;
            o_reg_rvalid <= 1'b0;
            o_events <= 32'h0000_0000;
        end else begin
            events <= next_events;
            o_reg_rdata <= next_rdata;
            o_reg_rvalid <= next_rvalid;
            o_events <= i_clk_en ? view : o_events;
        end
    end

    // ********************************
    // checks
    // ********************************
    // history only moves on enabled edges, so the past edge must be enabled
    sequence s_bus_reset_rise;
        i_clk_en && $past(i_clk_en) && i_phy_bus_reset &&
            !$past(i_phy_bus_reset);
    endsequence
    sequence s_reinit_seen;
        events[bus_reinit_bit] && !events[node_ident_done_bit];
    endsequence

    property p_reserved_zero;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        o_reg_rdata[14:10] == 5'h00 && o_events[14:10] == 5'h00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits not zero");

    property p_reinit_clears;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        s_bus_reset_rise |=> s_reinit_seen;
    endproperty
    a_reinit_clears: assert property (p_reinit_clears)
        else $error("bus reset did not clear ident done");

    property p_sticky_with_primary;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        $rose(events[node_ident_done_bit]) &&
            !$past(sw_set[node_ident_done_bit]) |->
            events[node_ident_sticky_bit];
    endproperty
    a_sticky_with_primary: assert property (p_sticky_with_primary)
        else $error("sticky ident not set with primary");

    property p_sticky_holds;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (s_bus_reset_rise and (events[node_ident_sticky_bit] &&
            !(i_reg_wr && i_reg_addr == clear_port_offset))) |=>
            events[node_ident_sticky_bit];
    endproperty
    a_sticky_holds: assert property (p_sticky_holds)
        else $error("sticky ident lost on bus reset");

    property p_synch_sets;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        i_clk_en && (i_cycle_count_lsb != $past(i_cycle_count_lsb)) &&
            $past(i_clk_en) |=> events[new_iso_cycle_bit];
    endproperty
    a_synch_sets: assert property (p_synch_sets)
        else $error("cycle synch flag not set");

    property p_access_fail;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        i_clk_en && $past(i_clk_en) && access_fail &&
            !$past(access_fail) |=>
            events[phy_clock_missing_bit];
    endproperty
    a_access_fail: assert property (p_access_fail)
        else $error("access failure not flagged");

    property p_clear_read;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        i_clk_en && i_reg_rd && i_reg_addr == clear_port_offset |=>
            o_reg_rvalid && ((o_reg_rdata & ~$past(i_int_mask)) == 0);
    endproperty
    a_clear_read: assert property (p_clear_read)
        else $error("clear port read not masked");

    property p_rx_summary;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        i_clk_en |=> o_events[iso_receive_bit] ==
            $past(|(i_iso_rx_event & i_iso_rx_mask));
    endproperty
    a_rx_summary: assert property (p_rx_summary)
        else $error("receive summary mismatch");

    property p_tx_summary;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        i_clk_en |=> o_events[iso_transmit_bit] ==
            $past(|(i_iso_tx_event & i_iso_tx_mask));
    endproperty
    a_tx_summary: assert property (p_tx_summary)
        else $error("transmit summary mismatch");

    property p_clear_only_by_port;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        events[atomic_reply_error_bit] &&
            !(i_clk_en && i_reg_wr && i_reg_addr == clear_port_offset) |=>
            events[atomic_reply_error_bit];
    endproperty
    a_clear_only_by_port: assert property (p_clear_only_by_port)
        else $error("event bit cleared without clear write");
endmodule
`default_nettype wire

// ==== verif/event_source_model.sv ====
// partner model: event source levels and iso contexts
`timescale 1ns/10ps
`default_nettype none
module event_source_model (
    input wire logic i_core_clk,
    output logic [11:0] o_lv,
    output logic [31:0] o_iso
);
    // ****
    // far-side drive
    // ****
    // phy clock starts present, everything else low
    initial begin
        o_lv = 12'h040;
        o_iso = 32'h0;
    end
    task automatic put(input int idx, input logic v);
        @(posedge i_core_clk);
        o_lv[idx] <= v;
    endtask
    task automatic pulse(input int idx);
        put(idx, 1'b1);
        put(idx, 1'b0);
    endtask
    task automatic iso(input logic [31:0] v);
        @(posedge i_core_clk);
        o_iso <= v;
    endtask
endmodule
`default_nettype wire

// ==== verif/host_interrupt_event_bits_tb.sv ====
// self-checking bench for the interrupt event bits
`timescale 1ns/10ps
`default_nettype none
module host_interrupt_event_bits_tb;
    import host_irq_event_pkg::*;
    logic i_core_clk, i_reset_n, i_clk_en, i_reg_wr, i_reg_rd, o_reg_rvalid;
    logic [7:0] i_reg_addr;
    logic [31:0] i_reg_wdata, i_int_mask, o_reg_rdata, o_events, iso;
    logic [11:0] lv;
    int n_mismatch = 0;
    int comparisons = 0;
    event_source_model model (.i_core_clk(i_core_clk), .o_lv(lv),
        .o_iso(iso));
    host_interrupt_event_bits #(.iso_contexts(8)) uut (
        .i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
        .i_int_mask(i_int_mask), .i_cycle_count_lsb(lv[0]),
        .i_cycle_seconds({lv[1], lv[11:6]}), .i_cycle_start_seen(lv[2]),
        .i_subaction_gap(lv[3]), .i_arb_reset_gap(lv[4]),
        .i_phy_status_irq(lv[5]), .i_phy_clock_present(lv[6]),
        .i_reg_access(lv[7]), .i_phy_bus_reset(lv[8]),
        .i_self_id_done(lv[9]), .i_lock_reply_no_ack(lv[10]),
        .i_posted_write_host_error(lv[11]), .i_iso_rx_event(iso[7:0]),
        .i_iso_rx_mask(iso[15:8]), .i_iso_tx_event(iso[23:16]),
        .i_iso_tx_mask(iso[31:24]), .o_events(o_events));
    // ****
    // shared tasks
    // ****
    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    function automatic logic [31:0] bitv(input int n);
        return 32'h1 << n;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_core_clk);
        i_reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_core_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_core_clk);
        i_reg_rd <= 1'b0;
        #1;
        check({31'h0, o_reg_rvalid}, 32'h1);
        check(o_reg_rdata, exp);
    endtask
    // o_events trails a source by up to two edges (one for the summaries); four leaves margin
    task automatic look(input logic [31:0] exp);
        repeat (4) @(posedge i_core_clk);
        #1;
        check(o_events, exp);
    endtask
    task automatic wipe();
        wr(clear_port_offset, 32'hffff_ffff);
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_software();
        @(posedge i_core_clk);
        i_int_mask <= 32'h0055_0300;
        wr(set_port_offset, 32'hffff_ffff);
        look(latched_mask);
        rd(clear_port_offset, latched_mask & 32'h0055_0300);
        rd(set_port_offset, latched_mask);
        rd(8'h88, 32'h0);
        wr(clear_port_offset, bitv(atomic_reply_error_bit));
        look(latched_mask & ~bitv(atomic_reply_error_bit));
        wipe();
        look(32'h0);
    endtask
    task automatic t_iso();
        model.iso(32'h0000_0404);
        look(bitv(iso_receive_bit));
        wr(clear_port_offset, 32'h0000_00c0);
        look(bitv(iso_receive_bit));
        model.iso(32'h0000_0004);
        look(32'h0);
        model.iso(32'h8080_0000);
        look(bitv(iso_transmit_bit));
        model.iso(32'h0);
        look(32'h0);
    endtask
    // low enable holds off edges and the summaries, and drops writes
    task automatic t_freeze();
        @(posedge i_core_clk);
        i_clk_en <= 1'b0;
        model.put(5, 1'b1);
        wr(set_port_offset, bitv(atomic_reply_error_bit));
        model.iso(32'h0000_0404);
        look(32'h0);
        @(posedge i_core_clk);
        i_clk_en <= 1'b1;
        look(bitv(phy_request_bit) | bitv(iso_receive_bit));
        model.put(5, 1'b0);
        model.iso(32'h0);
        wipe();
        look(32'h0);
    endtask
    task automatic t_sources();
        int src[3] = '{5, 10, 11};
        int bt[3] = '{phy_request_bit, atomic_reply_error_bit,
            buffered_write_error_bit};
        for (int i = 0; i < 3; i++) begin
            model.put(src[i], 1'b1);
            look(bitv(bt[i]));
            wr(clear_port_offset, bitv(bt[i]));
            look(32'h0);
            model.put(src[i], 1'b0);
        end
        model.pulse(7);
        look(32'h0);
        model.put(6, 1'b0);
        model.pulse(7);
        look(bitv(phy_clock_missing_bit));
        model.put(6, 1'b1);
        wipe();
        model.put(9, 1'b1);
        look(bitv(node_ident_done_bit) | bitv(node_ident_sticky_bit));
        model.put(8, 1'b1);
        look(bitv(bus_reinit_bit) | bitv(node_ident_sticky_bit));
        model.put(8, 1'b0);
        model.put(9, 1'b0);
        wipe();
    endtask
    task automatic t_cycle();
        int pk[3] = '{2, 3, 4};
        model.put(1, 1'b1);
        look(bitv(sixty_four_sec_bit));
        wipe();
        model.put(1, 1'b0);
        look(bitv(sixty_four_sec_bit));
        wipe();
        // case 0 has a start in time, the others lose the cycle
        for (int k = 0; k < 4; k++) begin
            model.put(0, ~lv[0]);
            repeat (2) @(posedge i_core_clk);
            if (k == 3) begin
                model.put(0, ~lv[0]);
            end else begin
                model.pulse(pk[k]);
            end
            look(bitv(new_iso_cycle_bit) |
                (k > 0 ? bitv(missed_cycle_bit) : 32'h0));
            model.pulse(2);
            wipe();
        end
        look(32'h0);
    endtask
    // ****
    // run control
    // ****
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        i_reset_n = 1'b0;
        i_clk_en = 1'b1;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        i_reg_addr = 8'h00;
        i_reg_wdata = 32'h0;
        i_int_mask = 32'h0;
        repeat (3) @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        look(32'h0);
        t_software();
        t_iso();
        t_freeze();
        t_sources();
        t_cycle();
        print_verdict();
    end
    // whole run needs about 220 cycles
    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
